// [src/sbrmt_cfg.svh]
// Offsets, field positions, reset values and timing counts for the request mask and watchdog block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef SBRMT_CFG_SVH
`define SBRMT_CFG_SVH

// Register offsets in configuration space
`define SBRMT_CTRL_OFFSET 8'hdd
`define SBRMT_FLAGS_OFFSET 8'hde

// Field positions
`define SBRMT_WD_ENABLE_BIT 7
`define SBRMT_AUTO_MASK_BIT 6
`define SBRMT_MASK_MSB 5
`define SBRMT_NUM_REQ 6

// Reset values
`define SBRMT_CTRL_RESET 8'h00
`define SBRMT_FLAGS_RESET 6'h00
`define SBRMT_RSVD_READ 2'h0

// Watchdog time, in bus clocks, and the terminal count derived from it
`define SBRMT_TIMEOUT_CLKS 16
`define SBRMT_WD_LAST_CNT (`SBRMT_TIMEOUT_CLKS - 1)

`endif

// [src/sbrmt_pkg.sv]
// Types shared by the request mask and watchdog block.
// Assumes nothing of its surroundings.
package sbrmt_pkg;

  typedef enum logic [1:0] {
    WD_OFF = 2'b00,
    WD_WATCH = 2'b01,
    WD_FIRED = 2'b10
  } sbrmt_wd_state_t;

endpackage : sbrmt_pkg

// [src/sbrmt_watchdog.sv]
// Grant watchdog: counts idle bus clocks while one master holds the grant.
// Assumes grant and idle are already in the bus clock domain.
`timescale 1ns/1ps
`include "sbrmt_cfg.svh"

module sbrmt_watchdog (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Control and bus view
  input wire logic watchEnable,
  input wire logic busIdle,
  input wire logic [5:0] grantVec,
  // Expiry, one cycle, one-hot on the granted master
  output logic [5:0] expiredVec_q
);

  sbrmt_pkg::sbrmt_wd_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [5:0] grant_q, grant_d;
  logic [5:0] expiredVec_d;
  logic qualify;

  ////////////////////////////////////////////////////////////////////////////
  // A grant change restarts the window, so a new owner always gets full time
  assign qualify = busIdle && (grantVec != 6'h00) && (grantVec == grant_q);

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    grant_d = grantVec;
    expiredVec_d = 6'h00;
    unique case (state_q)
      sbrmt_pkg::WD_OFF:
      begin
        cnt_d = 4'h0;
        if (watchEnable)
          state_d = sbrmt_pkg::WD_WATCH;
      end
      sbrmt_pkg::WD_WATCH:
      begin
        if (!watchEnable)
        begin
          state_d = sbrmt_pkg::WD_OFF;
          cnt_d = 4'h0;
        end
        else if (!qualify)
          cnt_d = 4'h0;
        else if (cnt_q == 4'(`SBRMT_WD_LAST_CNT))
        begin
          expiredVec_d = grantVec;
          state_d = sbrmt_pkg::WD_FIRED;
          cnt_d = 4'h0;
        end
        else
          cnt_d = cnt_q + 4'h1;
      end
      sbrmt_pkg::WD_FIRED:
      begin
        cnt_d = 4'h0;
        state_d = watchEnable ? sbrmt_pkg::WD_WATCH : sbrmt_pkg::WD_OFF;
      end
      default:
      begin
        state_d = sbrmt_pkg::WD_OFF;
        cnt_d = 4'h0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= sbrmt_pkg::WD_OFF;
      cnt_q <= 4'h0;
      grant_q <= 6'h00;
      expiredVec_q <= 6'h00;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      grant_q <= grant_d;
      expiredVec_q <= expiredVec_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Independent run counter for checking
  logic [4:0] run_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      run_q <= 5'h00;
    else if (!watchEnable || !qualify || (state_q != sbrmt_pkg::WD_WATCH) || (expiredVec_d != 6'h00))
      run_q <= 5'h00;
    else if (run_q != 5'h1f)
      run_q <= run_q + 5'h01;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  AST_WD_OFF_SILENT: assert property (!watchEnable |=> expiredVec_q == 6'h00)
    else $error("Watchdog fired while disabled");
  AST_WD_SIXTEEN: assert property ((expiredVec_d != 6'h00) |-> run_q == 5'd15)
    else $error("Watchdog fired after a wrong idle count");
  AST_WD_TARGET: assert property ((expiredVec_d != 6'h00) |=> expiredVec_q == $past(grantVec))
    else $error("Watchdog flagged a master that did not hold the grant");
  AST_WD_NO_LATE: assert property ((run_q == 5'd15) && qualify && watchEnable |-> expiredVec_d != 6'h00)
    else $error("Watchdog missed its terminal count");

endmodule : sbrmt_watchdog

// [src/sbrmt_top.sv]
// Request masking and grant watchdog beside the secondary bus arbiter.
// Assumes grants come from the arbiter core on clk; request, frame and irdy pins are asynchronous here.
`timescale 1ns/1ps
`include "sbrmt_cfg.svh"

module sbrmt_top (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Secondary bus pins, active low
  input wire logic [5:0] reqPin_n,
  input wire logic framePin_n,
  input wire logic irdyPin_n,
  // Grant from the arbiter core, one-hot, active high
  input wire logic [5:0] grantVec,
  // Requests handed to the arbiter core, active high
  output logic [5:0] reqToArbiter_q,
  // Configuration register port
  input wire logic [7:0] cfgAddr,
  input wire logic cfgWrEn,
  input wire logic [7:0] cfgWrData,
  input wire logic cfgRdEn,
  output logic [7:0] cfgRdData_q,
  output logic cfgRdValid_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage read by second stage only
  logic [7:0] pinMeta_q;
  logic [7:0] pinSync_q;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pinMeta_q <= 8'hff;
      pinSync_q <= 8'hff;
    end
    else
    begin
      pinMeta_q <= {framePin_n, irdyPin_n, reqPin_n};
      pinSync_q <= pinMeta_q;
    end
  end

  logic [5:0] reqActive;
  logic busIdle;

  assign reqActive = ~pinSync_q[5:0];
  // Idle means neither frame nor irdy asserted
  assign busIdle = pinSync_q[7] && pinSync_q[6];

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] ctrl_q, ctrl_d;
  logic [5:0] flags_q, flags_d;
  logic [5:0] reqToArbiter_d;
  logic [7:0] cfgRdData_d;
  logic cfgRdValid_d;
  logic [5:0] expiredVec;
  logic ctrlWrite;
  logic flagsWrite;
  logic [5:0] flagsClear;

  assign ctrlWrite = cfgWrEn && (cfgAddr == `SBRMT_CTRL_OFFSET);
  assign flagsWrite = cfgWrEn && (cfgAddr == `SBRMT_FLAGS_OFFSET);
  assign flagsClear = flagsWrite ? cfgWrData[`SBRMT_MASK_MSB:0] : 6'h00;

  sbrmt_watchdog sbrmt_watchdog_i (
    .clk(clk),
    .arst_n(arst_n),
    .watchEnable(ctrl_q[`SBRMT_WD_ENABLE_BIT]),
    .busIdle(busIdle),
    .grantVec(grantVec),
    .expiredVec_q(expiredVec)
  );

  always_comb
  begin
    ctrl_d = ctrl_q;
    if (ctrlWrite)
      ctrl_d = cfgWrData;
    // Hardware set wins over a software write in the same cycle
    if (ctrl_q[`SBRMT_AUTO_MASK_BIT])
      ctrl_d[`SBRMT_MASK_MSB:0] = ctrl_d[`SBRMT_MASK_MSB:0] | expiredVec;
  end

  // Write one to clear; a new expiry in the same cycle survives
  assign flags_d = (flags_q & ~flagsClear) | expiredVec;

  // Masked requests never reach the arbiter core
  assign reqToArbiter_d = reqActive & ~ctrl_q[`SBRMT_MASK_MSB:0];

  always_comb
  begin
    cfgRdData_d = 8'h00;
    cfgRdValid_d = cfgRdEn;
    if (cfgRdEn)
    begin
      unique case (cfgAddr)
        `SBRMT_CTRL_OFFSET: cfgRdData_d = ctrl_q;
        `SBRMT_FLAGS_OFFSET: cfgRdData_d = {`SBRMT_RSVD_READ, flags_q};
        default: cfgRdData_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_q <= `SBRMT_CTRL_RESET;
      flags_q <= `SBRMT_FLAGS_RESET;
      reqToArbiter_q <= 6'h00;
      cfgRdData_q <= 8'h00;
      cfgRdValid_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      flags_q <= flags_d;
      reqToArbiter_q <= reqToArbiter_d;
      cfgRdData_q <= cfgRdData_d;
      cfgRdValid_q <= cfgRdValid_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic rdFlags_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rdFlags_q <= 1'b0;
    else
      rdFlags_q <= cfgRdEn && (cfgAddr == `SBRMT_FLAGS_OFFSET);
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  AST_FLAG_SET: assert property ((expiredVec != 6'h00) |=> (flags_q & $past(expiredVec)) == $past(expiredVec))
    else $error("Expiry did not set its flag");
  AST_FLAG_STICKY: assert property (!flagsWrite |=> (flags_q & $past(flags_q)) == $past(flags_q))
    else $error("Flag dropped without a software clear");
  AST_FLAG_CLEAR: assert property (flagsWrite && (expiredVec == 6'h00) |=> (flags_q & $past(flagsClear)) == 6'h00)
    else $error("Software clear of a flag had no effect");
  AST_RSVD_ZERO: assert property (cfgRdValid_q && rdFlags_q |-> cfgRdData_q[7:6] == 2'b00)
    else $error("Reserved flag bits read nonzero");
  AST_AUTO_MASK: assert property (ctrl_q[6] && (expiredVec != 6'h00) |=> (ctrl_q[5:0] & $past(expiredVec)) == $past(expiredVec))
    else $error("Timed-out request not masked");
  AST_NO_AUTO_MASK: assert property (!ctrl_q[6] && !ctrlWrite |=> ctrl_q == $past(ctrl_q))
    else $error("Mask changed without auto-mask or write");
  AST_MASK_HOLD: assert property (!ctrlWrite |=> (ctrl_q[5:0] & $past(ctrl_q[5:0])) == $past(ctrl_q[5:0]))
    else $error("Mask bit lost without a software write");
  AST_MASK_GATES: assert property (ctrl_q[0] |=> !reqToArbiter_q[0])
    else $error("Masked request reached the arbiter");
  // Output lags the synchroniser by one edge, so the synchronised requests must hold still across it
  AST_REQ_PASS: assert property (ctrl_q[5:0] == 6'h00 ##1 $stable(pinSync_q[5:0]) |->
    reqToArbiter_q == ~pinSync_q[5:0])
    else $error("Unmasked request not passed through");

  ////////////////////////////////////////////////////////////////////////////
  // Source and readback checks
  AST_FLAG_CAUSE: assert property (((flags_q & ~$past(flags_q)) & ~$past(expiredVec)) == 6'h00)
    else $error("Flag set without an expiry");
  AST_FLAG_READBACK: assert property (cfgRdValid_q && rdFlags_q |-> cfgRdData_q[5:0] == $past(flags_q))
    else $error("Flag read did not return the stored flags");
  // Auto-mask may only add the request that just timed out
  AST_MASK_ONLY_TARGET: assert property (ctrl_q[6] && !ctrlWrite |=>
    (ctrl_q[5:0] & ~$past(ctrl_q[5:0]) & ~$past(expiredVec)) == 6'h00)
    else $error("Auto-mask set a request that did not time out");
  // A plain write lands whole when no auto-mask can race it
  AST_CTRL_WRITE: assert property (ctrlWrite && !ctrl_q[6] |=> ctrl_q == $past(cfgWrData))
    else $error("Control write did not land");
  AST_WD_DISABLED_TOP: assert property (!ctrl_q[`SBRMT_WD_ENABLE_BIT] |=> expiredVec == 6'h00)
    else $error("Expiry seen while watchdog disabled");

  ////////////////////////////////////////////////////////////////////////////
  // Per-request gating; every input checked, not just input 0
  for (genvar r = 0; r < `SBRMT_NUM_REQ; r++)
  begin : g_gate
    AST_MASK_GATES_EACH: assert property (ctrl_q[r] |=> !reqToArbiter_q[r])
      else $error("Masked request reached the arbiter");
    AST_USE_EACH: assert property (!ctrl_q[r] |=> reqToArbiter_q[r] == !$past(pinSync_q[r]))
      else $error("Unmasked request not passed through");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low only on the first edge after reset, where reset values must still stand
  logic afterReset_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      afterReset_q <= 1'b0;
    else
      afterReset_q <= 1'b1;
  end

  AST_RESET_CTRL: assert property (!afterReset_q |-> ctrl_q == `SBRMT_CTRL_RESET)
    else $error("Control register not cleared by reset");
  AST_RESET_FLAGS: assert property (!afterReset_q |-> flags_q == `SBRMT_FLAGS_RESET)
    else $error("Flags not cleared by reset");
  AST_RESET_OUTPUTS: assert property (!afterReset_q |-> reqToArbiter_q == 6'h00 && !cfgRdValid_q)
    else $error("Outputs not cleared by reset");

  COV_EXPIRE: cover property (expiredVec != 6'h00);
  COV_AUTO_MASK: cover property (ctrl_q[6] && (expiredVec != 6'h00));
  COV_SET_AND_CLEAR: cover property (flagsWrite && ((flagsClear & expiredVec) != 6'h00));
  COV_FLAG_READ: cover property (cfgRdValid_q && rdFlags_q && cfgRdData_q != 8'h00);
  COV_GATED: cover property (ctrl_q[0] && reqActive[0]);

endmodule : sbrmt_top

// [testbench/sbrmt_masters.sv]
// Behavioural group of secondary bus masters facing the request mask block.
// Assumes grants come from the bench on clk; released bus lines float high through pull-ups.
`timescale 1ns/1ps

module sbrmt_masters (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Bench control
  input wire logic [5:0] grantVec,
  input wire logic [5:0] reqWant,
  input wire logic respond,
  // Bus pins, active low
  output logic [5:0] reqPin_n,
  output logic framePin_n,
  output logic irdyPin_n
);
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reqPin_n <= 6'h3f;
      framePin_n <= 1'b1;
      irdyPin_n <= 1'b1;
    end
    else
    begin
      reqPin_n <= ~reqWant;
      // A hung master leaves frame to its pull-up
      framePin_n <= ~(respond & (|grantVec));
      irdyPin_n <= ~(respond & (|grantVec));
    end
  end
endmodule : sbrmt_masters

// [testbench/sbrmt_top_bench.sv]
// Self-checking bench for the request mask and grant watchdog block.
// Assumes the design files and sbrmt_cfg.svh are compiled first.
`timescale 1ns/1ps
`include "sbrmt_cfg.svh"
`define CHK(what, exp, got) \
  begin \
    checksDone++; \
    if ((got) !== (exp)) \
    begin \
      $display("Error %s expected %h seen %h", what, exp, got); \
      errors++; \
    end \
  end

module sbrmt_top_bench;
  logic clk, arst_n, respond, cfgWrEn, cfgRdEn;
  logic [5:0] reqWant, grantVec, maskVal, expFlags;
  logic [7:0] cfgAddr, cfgWrData, lfsr, expRd;
  wire logic [5:0] reqPin_n, reqToArbiter_q;
  wire logic framePin_n, irdyPin_n, cfgRdValid_q;
  wire logic [7:0] cfgRdData_q;
  logic [7:0] expQ[$];
  int errors = 0;
  int checksDone = 0;

  sbrmt_top sbrmt_top_i (.clk(clk), .arst_n(arst_n), .reqPin_n(reqPin_n), .framePin_n(framePin_n),
    .irdyPin_n(irdyPin_n), .grantVec(grantVec), .reqToArbiter_q(reqToArbiter_q), .cfgAddr(cfgAddr),
    .cfgWrEn(cfgWrEn), .cfgWrData(cfgWrData), .cfgRdEn(cfgRdEn), .cfgRdData_q(cfgRdData_q),
    .cfgRdValid_q(cfgRdValid_q));
  sbrmt_masters sbrmt_masters_i (.clk(clk), .arst_n(arst_n), .grantVec(grantVec), .reqWant(reqWant),
    .respond(respond), .reqPin_n(reqPin_n), .framePin_n(framePin_n), .irdyPin_n(irdyPin_n));

  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsrNext(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsrNext

  task automatic waitClk(input int n);
    repeat (n) @(negedge clk);
  endtask : waitClk

  task automatic cfgWrite(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk);
    cfgAddr = addr;
    cfgWrData = data;
    cfgWrEn = 1'b1;
    @(negedge clk);
    cfgWrEn = 1'b0;
  endtask : cfgWrite

  // Expected data queued here, checked by the monitor
  task automatic cfgRead(input logic [7:0] addr, input logic [7:0] exp);
    @(negedge clk);
    cfgAddr = addr;
    cfgRdEn = 1'b1;
    expQ.push_back(exp);
    @(negedge clk);
    cfgRdEn = 1'b0;
  endtask : cfgRead

  task automatic complete_run();
    $display("Checks %0d errors %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Sampled mid-cycle, where the one-cycle read answer has settled
  always @(negedge clk)
  begin
    if (cfgRdValid_q === 1'b1)
    begin
      expRd = (expQ.size() > 0) ? expQ.pop_front() : 8'hxx;
      `CHK("cfgRdData_q", expRd, cfgRdData_q)
    end
  end

  // Run needs well under a thousand cycles
  initial
  begin
    #(3000 * 40);
    errors++;
    complete_run();
  end

  initial
  begin
    arst_n = 1'b0;
    reqWant = 6'h00;
    respond = 1'b0;
    grantVec = 6'h00;
    cfgAddr = 8'h00;
    cfgWrEn = 1'b0;
    cfgWrData = 8'h00;
    cfgRdEn = 1'b0;
    lfsr = 8'h07;
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    cfgRead(`SBRMT_CTRL_OFFSET, 8'h00);
    cfgRead(`SBRMT_FLAGS_OFFSET, 8'h00);
    cfgRead(8'hdc, 8'h00); // Unmapped offset reads zero
    repeat (8)
    begin
      lfsr = lfsrNext(lfsr);
      reqWant = lfsr[5:0];
      lfsr = lfsrNext(lfsr);
      maskVal = lfsr[5:0];
      cfgWrite(`SBRMT_CTRL_OFFSET, {2'b00, maskVal});
      waitClk(4);
      `CHK("reqToArbiter_q", reqWant & ~maskVal, reqToArbiter_q)
    end
    cfgWrite(`SBRMT_CTRL_OFFSET, 8'h00);
    reqWant = 6'h3f;
    grantVec = 6'h04;
    waitClk(30);
    cfgRead(`SBRMT_FLAGS_OFFSET, 8'h00);
    grantVec = 6'h00;
    cfgWrite(`SBRMT_CTRL_OFFSET, 8'h80);
    respond = 1'b1;
    grantVec = 6'h08;
    waitClk(30);
    cfgRead(`SBRMT_FLAGS_OFFSET, 8'h00);
    grantVec = 6'h00;
    waitClk(2);
    respond = 1'b0;
    expFlags = 6'h00;
    for (int g = 0; g < 6; g++)
    begin
      grantVec = 6'h01 << g;
      waitClk(12);
      cfgRead(`SBRMT_FLAGS_OFFSET, {2'b00, expFlags});
      waitClk(10);
      grantVec = 6'h00;
      expFlags[g] = 1'b1;
      cfgRead(`SBRMT_FLAGS_OFFSET, {2'b00, expFlags});
    end
    cfgRead(`SBRMT_CTRL_OFFSET, 8'h80);
    cfgRead(`SBRMT_FLAGS_OFFSET, 8'h3f);
    cfgWrite(`SBRMT_FLAGS_OFFSET, 8'h00);
    cfgRead(`SBRMT_FLAGS_OFFSET, 8'h3f);
    cfgWrite(`SBRMT_FLAGS_OFFSET, 8'hff);
    cfgRead(`SBRMT_FLAGS_OFFSET, 8'h00);
    cfgWrite(`SBRMT_CTRL_OFFSET, 8'hc0);
    grantVec = 6'h10;
    waitClk(24);
    grantVec = 6'h00;
    waitClk(4);
    cfgRead(`SBRMT_CTRL_OFFSET, 8'hd0);
    cfgRead(`SBRMT_FLAGS_OFFSET, 8'h10);
    `CHK("reqToArbiter_q", 6'h2f, reqToArbiter_q)
    respond = 1'b1;
    waitClk(20);
    cfgRead(`SBRMT_CTRL_OFFSET, 8'hd0);
    cfgWrite(`SBRMT_CTRL_OFFSET, 8'hc0);
    waitClk(4);
    `CHK("reqToArbiter_q", 6'h3f, reqToArbiter_q)
    waitClk(4);
    // Second reset with both enables and a flag still set, mask already cleared
    arst_n = 1'b0;
    waitClk(2);
    arst_n = 1'b1;
    cfgRead(`SBRMT_CTRL_OFFSET, 8'h00);
    cfgRead(`SBRMT_FLAGS_OFFSET, 8'h00);
    waitClk(4);
    `CHK("readsPending", 0, expQ.size())
    complete_run();
  end
endmodule : sbrmt_top_bench
